//--- design/mem_route.sv
`include "mem_route_consts.svh"

module mem_route (
	// Clock and reset
	input  wire logic                   clk_in,
	input  wire logic                   rst_b_in,
	// CPU request
	input  wire logic                   req_valid_in,
	input  wire logic [`ADDR_W-1:0]     req_addr_in,
	input  wire logic                   req_write_in,
	input  wire logic                   req_byte_in,
	input  wire logic                   req_fetch_in,
	// Configuration
	input  wire logic                   bootstrap_pin_in,
	input  wire logic                   global_xbus_enable_in,
	input  wire logic [`EN_W-1:0]       xbus_peripheral_enable_reg_in,
	// Flash bank status
	input  wire logic                   flash_bank_a_busy_in,
	input  wire logic                   flash_bank_b_busy_in,
	// Target answer
	input  wire logic                   target_ack_in,
	// CPU answer
	output logic                        req_ready_out,
	output logic                        req_error_out,
	output logic                        busy_out,
	// Routed access
	output mem_route_pkg::target_t      target_out,
	output logic                        strobe_out,
	output logic [`ADDR_W-1:0]          route_addr_out,
	output logic                        route_write_out,
	output logic                        route_byte_out,
	output logic                        flash_bank_b_out,
	output logic                        path_wide_out,
	output logic [1:0]                  wait_states_out,
	output logic                        standby_area_out,
	// Peripheral occupancy
	output logic [`ACT_W-1:0]           periph_active_out,
	output logic [3:0]                  seg_lines_out
);
	import mem_route_pkg::*;

	// Whole state of the router
	typedef struct packed {
		route_st_t           st;
		logic                boot_s1;
		logic                boot_s2;
		target_t             tgt;
		logic [`ADDR_W-1:0]  addr;
		logic                wr;
		logic                byt;
		logic                bank_b;
		logic                wide;
		logic [1:0]          ws;
		logic                stby;
		logic                timed;
		logic [`CNT_W-1:0]   cnt;
		logic                ready;
		logic                err;
		logic                busy;
		logic                strb;
		logic [`ACT_W-1:0]   act;
		logic [3:0]          seg;
	} route_state_t;

	route_state_t  state_r;
	route_state_t  state_nxt;
	route_dec_if   dec_bus ();
	logic          take;
	logic          bad_width;
	logic          bad_bank;
	logic          done_now;

	// Decoder inputs: live request address and current enables
	assign dec_bus.addr = req_addr_in;
	assign dec_bus.boot = state_r.boot_s2;
	assign dec_bus.gxen = global_xbus_enable_in;
	assign dec_bus.xper = xbus_peripheral_enable_reg_in;

	route_decode u_dec (
		.d (dec_bus.dec)
	);

	// Request taken only while idle
	assign take = req_valid_in && (state_r.st == ST_IDLE);

	// Byte access to a word-only peripheral window is refused
	assign bad_width = dec_bus.word_only && req_byte_in;

	// Read of a bank under modification is refused, other bank still served
	assign bad_bank = (dec_bus.tgt == TGT_FLASH) && !req_write_in
		&& (dec_bus.bank_b ? flash_bank_b_busy_in : flash_bank_a_busy_in);

	// Access end: self-timed count or the target's acknowledge
	assign done_now = state_r.timed ? (state_r.cnt == '0) : target_ack_in;

	// Next-state logic
	always_comb
	begin
		state_nxt       = state_r;
		state_nxt.ready = 1'b0;
		state_nxt.err   = 1'b0;

		// Strap crosses in through two flops
		state_nxt.boot_s1 = bootstrap_pin_in;
		state_nxt.boot_s2 = state_r.boot_s1;

		// Occupancy follows both enables every cycle
		state_nxt.act = '0;
		if (global_xbus_enable_in)
		begin
			state_nxt.act = xbus_peripheral_enable_reg_in[`ACT_W-1:0];
		end

		// Segment lines shrink when a CAN controller is present
		if (state_nxt.act[`EN_CAN_A] || state_nxt.act[`EN_CAN_B])
			state_nxt.seg = `SEG_CAN;
		else
			state_nxt.seg = `SEG_FULL;

		case (state_r.st)
			ST_IDLE:
			begin
				if (take)
				begin
					state_nxt.busy = 1'b1;
					// Request copy is shown for refused and routed accesses alike
					state_nxt.addr = req_addr_in;
					state_nxt.wr   = req_write_in;
					state_nxt.byt  = req_byte_in;
					if (bad_width || bad_bank)
					begin
						state_nxt.st    = ST_DONE;
						state_nxt.err   = 1'b1;
						state_nxt.ready = 1'b1;
						state_nxt.tgt   = TGT_EXT;
						state_nxt.strb  = 1'b0;
					end
					else
					begin
						state_nxt.st     = ST_ACCESS;
						state_nxt.strb   = 1'b1;
						// Exactly one target, latched for the whole access
						state_nxt.tgt    = dec_bus.tgt;
						state_nxt.bank_b = dec_bus.bank_b;
						state_nxt.ws     = dec_bus.ws;
						state_nxt.stby   = dec_bus.stby;
						state_nxt.timed  = dec_bus.timed;
						state_nxt.cnt    = dec_bus.cycles - `CNT_W'(1);
						// Wide path only for instruction fetches from flash
						state_nxt.wide   = req_fetch_in && !req_write_in
							&& (dec_bus.tgt == TGT_FLASH || dec_bus.tgt == TGT_TFLASH);
					end
				end
			end
			ST_ACCESS:
			begin
				if (done_now)
				begin
					state_nxt.st    = ST_DONE;
					state_nxt.ready = 1'b1;
					state_nxt.strb  = 1'b0;
				end
				else if (state_r.timed)
				begin
					state_nxt.cnt = state_r.cnt - `CNT_W'(1);
				end
			end
			ST_DONE:
			begin
				state_nxt.st   = ST_IDLE;
				state_nxt.busy = 1'b0;
			end
			default:
			begin
				state_nxt.st   = ST_IDLE;
				state_nxt.busy = 1'b0;
				state_nxt.strb = 1'b0;
			end
		endcase
	end

	// State register with synchronous reset
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			state_r <= '{
				st:      ST_IDLE,
				boot_s1: 1'b0,
				boot_s2: 1'b0,
				tgt:     TGT_EXT,
				addr:    '0,
				wr:      1'b0,
				byt:     1'b0,
				bank_b:  1'b0,
				wide:    1'b0,
				ws:      `WS_XRAM,
				stby:    1'b0,
				timed:   1'b0,
				cnt:     '0,
				ready:   1'b0,
				err:     1'b0,
				busy:    1'b0,
				strb:    1'b0,
				act:     '0,
				seg:     `SEG_FULL
			};
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// Outputs straight from the state register
	assign req_ready_out     = state_r.ready;
	assign req_error_out     = state_r.err;
	assign busy_out          = state_r.busy;
	assign target_out        = state_r.tgt;
	assign strobe_out        = state_r.strb;
	assign route_addr_out    = state_r.addr;
	assign route_write_out   = state_r.wr;
	assign route_byte_out    = state_r.byt;
	assign flash_bank_b_out  = state_r.bank_b;
	assign path_wide_out     = state_r.wide;
	assign wait_states_out   = state_r.ws;
	assign standby_area_out  = state_r.stby;
	assign periph_active_out = state_r.act;
	assign seg_lines_out     = state_r.seg;

	// reserved areas decode to TGT_SFR and TGT_ESFR, 512 bytes each

endmodule

//--- design/mem_route_consts.svh
`ifndef MEM_ROUTE_CONSTS_SVH
`define MEM_ROUTE_CONSTS_SVH

// Address space
`define ADDR_W         24
`define SEG_W          8
`define TF_END         24'h001fff
`define FL_LO_END      24'h007fff
`define FL_HI_BASE     24'h018000
`define FL_HI_END      24'h08ffff
`define FL_BANK_B_BASE 24'h070000
`define FCTL_BASE      24'h0e0000
`define FCTL_END       24'h0effff
`define XRS_BASE       24'h00e000
`define XRS_END        24'h00e7ff
`define XRL_BASE       24'h0f0000
`define XRL_END        24'h0f7fff
`define STBY_END       24'h0f3fff
`define ESFR_BASE      24'h00f000
`define ESFR_END       24'h00f1ff
`define IRAM_BASE      24'h00f600
`define IRAM_END       24'h00fdff
`define SFR_BASE       24'h00fe00
`define SFR_END        24'h00ffff

// Peripheral window pages (address bits 23..8)
`define PG_CAN_A       16'h00ef
`define PG_CAN_B       16'h00ee
`define PG_RTC         16'h00ed
`define PG_PWM         16'h00ec
`define PG_I2C         16'h00ea
`define PG_MISC        16'h00eb
`define PG_ASC         16'h00e9
`define PG_SSC         16'h00e8

// Enable bit positions in the peripheral enable word
`define EN_W           16
`define EN_CAN_A       0
`define EN_CAN_B       1
`define EN_XRS         2
`define EN_XRL         3
`define EN_RTC         4
`define EN_PWM         6
`define EN_ASC         7
`define EN_SSC         8
`define EN_I2C         9
`define EN_MISC        10
`define ACT_W          11

// Wait states and segment lines
`define WS_XRAM        2'h0
`define WS_XPER        2'h2
`define SEG_FULL       4'h8
`define SEG_CAN        4'h4

// Access times in ps, and cycle counts derived from the clock
`define CLK_PERIOD_PS  10000
`define XRAM_ACCESS_PS 31250
`define XPER_ACCESS_PS 62500
`define XRAM_CYC       ((`XRAM_ACCESS_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define XPER_CYC       ((`XPER_ACCESS_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CNT_W          4

`endif

//--- design/mem_route_pkg.sv
`include "mem_route_consts.svh"

package mem_route_pkg;

	// Routing targets
	typedef enum logic [4:0] {
		TGT_EXT    = 5'h00,
		TGT_FLASH  = 5'h01,
		TGT_TFLASH = 5'h02,
		TGT_FCTL   = 5'h03,
		TGT_IRAM   = 5'h04,
		TGT_SFR    = 5'h05,
		TGT_ESFR   = 5'h06,
		TGT_XRS    = 5'h07,
		TGT_XRL    = 5'h08,
		TGT_CAN_A  = 5'h09,
		TGT_CAN_B  = 5'h0a,
		TGT_RTC    = 5'h0b,
		TGT_PWM    = 5'h0c,
		TGT_ASC    = 5'h0d,
		TGT_SSC    = 5'h0e,
		TGT_I2C    = 5'h0f,
		TGT_MISC   = 5'h10
	} target_t;

	// Access sequencer states
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ACCESS = 2'b01,
		ST_DONE   = 2'b10
	} route_st_t;

endpackage

//--- design/route_dec_if.sv
`include "mem_route_consts.svh"

// Decode request and answer between sequencer and address decoder
interface route_dec_if;
	import mem_route_pkg::*;
	logic [`ADDR_W-1:0] addr;
	logic               boot;
	logic               gxen;
	logic [`EN_W-1:0]   xper;
	target_t            tgt;
	logic               word_only;
	logic               timed;
	logic [`CNT_W-1:0]  cycles;
	logic [1:0]         ws;
	logic               bank_b;
	logic               stby;
	modport dec (input addr, boot, gxen, xper,
		output tgt, word_only, timed, cycles, ws, bank_b, stby);
	modport seq (output addr, boot, gxen, xper,
		input tgt, word_only, timed, cycles, ws, bank_b, stby);
endinterface

//--- design/route_decode.sv
`include "mem_route_consts.svh"

module route_decode (
	// Decode port
	route_dec_if.dec d
);
	import mem_route_pkg::*;

	localparam int      NWIN = 8;
	localparam logic [15:0] WIN_PAGE [NWIN] = '{`PG_CAN_A, `PG_CAN_B, `PG_RTC, `PG_PWM,
		`PG_ASC, `PG_SSC, `PG_I2C, `PG_MISC};
	localparam int      WIN_BIT [NWIN] = '{`EN_CAN_A, `EN_CAN_B, `EN_RTC, `EN_PWM,
		`EN_ASC, `EN_SSC, `EN_I2C, `EN_MISC};
	localparam target_t WIN_TGT [NWIN] = '{TGT_CAN_A, TGT_CAN_B, TGT_RTC, TGT_PWM,
		TGT_ASC, TGT_SSC, TGT_I2C, TGT_MISC};

	logic [NWIN-1:0] hit;
	logic [15:0]     page;

	assign page = d.addr[`ADDR_W-1:8];

	// One match per peripheral window, gated by both enables
	genvar g;
	generate
		for (g = 0; g < NWIN; g++)
		begin : g_win
			assign hit[g] = d.gxen && d.xper[WIN_BIT[g]] && (page == WIN_PAGE[g]);
		end
	endgenerate

	// Priority decode: boot flash overlaps low flash and is checked first, so the first matching range wins
	always_comb
	begin
		d.tgt       = TGT_EXT;
		d.word_only = 1'b0;
		d.timed     = 1'b0;
		d.cycles    = '0;
		d.ws        = `WS_XRAM;
		d.bank_b    = 1'b0;
		d.stby      = 1'b0;
		if (d.boot && d.addr <= `TF_END)
			d.tgt = TGT_TFLASH;
		else if (d.addr <= `FL_LO_END || (d.addr >= `FL_HI_BASE && d.addr <= `FL_HI_END))
		begin
			d.tgt    = TGT_FLASH;
			d.bank_b = (d.addr >= `FL_BANK_B_BASE);
		end
		else if (d.addr >= `FCTL_BASE && d.addr <= `FCTL_END)
			d.tgt = TGT_FCTL;
		else if (d.addr >= `ESFR_BASE && d.addr <= `ESFR_END)
			d.tgt = TGT_ESFR;
		else if (d.addr >= `SFR_BASE && d.addr <= `SFR_END)
			d.tgt = TGT_SFR;
		else if (d.addr >= `IRAM_BASE && d.addr <= `IRAM_END)
			d.tgt = TGT_IRAM;
		else if (d.gxen && d.xper[`EN_XRS] && d.addr >= `XRS_BASE && d.addr <= `XRS_END)
			d.tgt = TGT_XRS;
		else if (d.gxen && d.xper[`EN_XRL] && d.addr >= `XRL_BASE && d.addr <= `XRL_END)
		begin
			d.tgt  = TGT_XRL;
			d.stby = (d.addr <= `STBY_END);
		end
		else
		begin
			for (int i = 0; i < NWIN; i++)
			begin
				if (hit[i])
				begin
					d.tgt       = WIN_TGT[i];
					d.word_only = 1'b1;
					d.ws        = `WS_XPER;
				end
			end
		end
		if (d.tgt == TGT_XRS || d.tgt == TGT_XRL)
		begin
			d.timed  = 1'b1;
			d.cycles = `CNT_W'(`XRAM_CYC);
		end
		else if (d.word_only)
		begin
			d.timed  = 1'b1;
			d.cycles = `CNT_W'(`XPER_CYC);
		end
	end

endmodule

//--- bench/ack_model.sv
`include "mem_route_consts.svh"

module ack_model (
	// Clock and reset
	input	wire logic		clk_in,
	input	wire logic		rst_b_in,
	// Routed access
	input	wire logic		strobe_in,
	input	wire logic [2:0]	delay_in,
	// Target answer
	output	logic			ack_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0]	cnt_r;

	// One ack pulse after a variable wait; timed targets ignore it
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in || !strobe_in)
		begin
			cnt_r <= 3'h0;
			ack_out <= 1'b0;
		end
		else
		begin
			ack_out <= !ack_out && cnt_r >= delay_in;
			cnt_r <= cnt_r + 3'h1;
		end
	end
endmodule

//--- bench/mem_route_monitor.sv
`include "mem_route_consts.svh"

module mem_route_monitor (
	// Clock and reset
	input	wire logic			clk_in,
	input	wire logic			rst_b_in,
	// CPU side
	input	wire logic			req_valid_in,
	input	wire logic [`ADDR_W-1:0]	req_addr_in,
	input	wire logic			req_ready_out,
	input	wire logic			req_error_out,
	input	wire logic			busy_out,
	// Routed access
	input	wire mem_route_pkg::target_t	target_out,
	input	wire logic			strobe_out,
	input	wire logic [`ADDR_W-1:0]	route_addr_out,
	input	wire logic			route_write_out,
	input	wire logic			flash_bank_b_out,
	input	wire logic			path_wide_out,
	input	wire logic [1:0]		wait_states_out,
	input	wire logic			standby_area_out,
	input	wire logic [`ACT_W-1:0]	periph_active_out,
	input	wire logic [3:0]		seg_lines_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import mem_route_pkg::*;

	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	// Request capture, access timing and routing
	accept_load_a: assert property (req_valid_in && !busy_out
		|=> busy_out && route_addr_out == $past(req_addr_in)) else $error("request not taken");
	xram_time_a: assert property ($rose(strobe_out) && target_out inside {TGT_XRS, TGT_XRL}
		|-> strobe_out [*4] ##1 (req_ready_out && !strobe_out)) else $error("ram access time wrong");
	periph_time_a: assert property ($rose(strobe_out) && target_out >= TGT_CAN_A
		|-> strobe_out [*7] ##1 (req_ready_out && !strobe_out)) else $error("window access time wrong");
	wait_state_a: assert property (strobe_out
		|-> wait_states_out == (target_out >= TGT_CAN_A ? 2'h2 : 2'h0)) else $error("wait states wrong");
	refuse_ext_a: assert property (req_error_out
		|-> req_ready_out && !strobe_out && target_out == TGT_EXT) else $error("refusal malformed");
	route_hold_a: assert property (busy_out && $past(busy_out)
		|-> $stable(target_out) && $stable(route_addr_out)) else $error("route moved in access");
	flash_bank_a: assert property (strobe_out && target_out == TGT_FLASH
		|-> flash_bank_b_out == (route_addr_out >= `FL_BANK_B_BASE)) else $error("bank flag wrong");
	wide_path_a: assert property (strobe_out && path_wide_out
		|-> !route_write_out && target_out inside {TGT_FLASH, TGT_TFLASH}) else $error("wide path wrong");
	standby_map_a: assert property (strobe_out
		|-> standby_area_out == (target_out == TGT_XRL && route_addr_out <= `STBY_END)) else $error("standby wrong");
	seg_lines_a: assert property ($stable(periph_active_out) [*2]
		|-> seg_lines_out == (|periph_active_out[1:0] ? 4'h4 : 4'h8)) else $error("segment lines wrong");

	// Main scenarios
	cover property ($rose(strobe_out) && target_out == TGT_XRS);
	cover property ($rose(strobe_out) && target_out == TGT_TFLASH);
	cover property (req_error_out);
endmodule

bind mem_route mem_route_monitor i_mon (.*);

//--- bench/mem_route_tb.sv
`include "mem_route_consts.svh"

module mem_route_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mem_route_pkg::*;

	logic			clk_in, rst_b_in, target_ack_in, bootstrap_pin_in, global_xbus_enable_in;
	logic			req_valid_in, req_write_in, req_byte_in, req_fetch_in;
	logic			flash_bank_a_busy_in, flash_bank_b_busy_in;
	logic [`ADDR_W-1:0]	req_addr_in, route_addr_out;
	logic [`EN_W-1:0]	xbus_peripheral_enable_reg_in;
	logic			req_ready_out, req_error_out, busy_out, strobe_out, route_write_out;
	logic			route_byte_out, flash_bank_b_out, path_wide_out, standby_area_out;
	target_t		target_out;
	logic [1:0]		wait_states_out;
	logic [`ACT_W-1:0]	periph_active_out;
	logic [3:0]		seg_lines_out;
	logic [2:0]		dly;
	logic [36:0]		notes[$];
	logic [36:0]		exp_n;
	int			n_errors = 0;
	int			total_checks = 0;
	logic [23:0]		map_a [15] = '{24'h000000, 24'h007fff, 24'h008000, 24'h018000, 24'h08ffff,
		24'h090000, 24'h00e000, 24'h00e7ff, 24'h0f0000, 24'h0f7fff, 24'h0f8000, 24'h0e0000,
		24'h00f000, 24'h00fe00, 24'h00f600};
	target_t		map_t [15] = '{TGT_FLASH, TGT_FLASH, TGT_EXT, TGT_FLASH, TGT_FLASH, TGT_EXT,
		TGT_XRS, TGT_XRS, TGT_XRL, TGT_XRL, TGT_EXT, TGT_FCTL, TGT_ESFR, TGT_SFR, TGT_IRAM};
	logic [7:0]		per_p [8] = '{8'hef, 8'hee, 8'hed, 8'hec, 8'he9, 8'he8, 8'hea, 8'heb};
	int			per_b [8] = '{0, 1, 4, 6, 7, 8, 9, 10};
	target_t		per_t [8] = '{TGT_CAN_A, TGT_CAN_B, TGT_RTC, TGT_PWM, TGT_ASC, TGT_SSC,
		TGT_I2C, TGT_MISC};

	mem_route i_dut (.*);

	ack_model i_ack (
		.clk_in		(clk_in),
		.rst_b_in	(rst_b_in),
		.strobe_in	(strobe_out),
		.delay_in	(dly),
		.ack_out	(target_ack_in)
	);

	// Clock
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Mismatch report
	task automatic report(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_route(input logic [5:0] got, input logic [5:0] exp);
		report({26'h0, got}, {26'h0, exp});
	endtask

	task automatic cmp_cfg(input logic [14:0] got, input logic [14:0] exp);
		report({17'h0, got}, {17'h0, exp});
	endtask

	// Routed address, direction and width
	task automatic cmp_path(input logic [25:0] got, input logic [25:0] exp);
		report({6'h0, got}, {6'h0, exp});
	endtask

	// Data path width, wait states, stand-by area and bank
	task automatic cmp_side(input logic [4:0] got, input logic [4:0] exp);
		report({27'h0, got}, {27'h0, exp});
	endtask

	// One CPU access; the expected target and error go to the queue
	task automatic acc(input logic [23:0] a, input logic w, input logic b, input logic f,
		input target_t t, input logic e);
		do @(negedge clk_in); while (busy_out !== 1'b0);
		@(posedge clk_in);
		req_valid_in <= 1'b1;
		req_addr_in <= a;
		req_write_in <= w;
		req_byte_in <= b;
		req_fetch_in <= f;
		dly <= 3'($urandom_range(4));
		notes.push_back({a, w, b, f && !w && t inside {TGT_FLASH, TGT_TFLASH},
			t >= TGT_CAN_A ? `WS_XPER : `WS_XRAM, t == TGT_XRL && a <= `STBY_END,
			t == TGT_FLASH && a >= `FL_BANK_B_BASE, t, e});
		@(posedge clk_in);
		req_valid_in <= 1'b0;
	endtask

	// New enables, then occupancy and segment lines
	task automatic cfg(input logic g, input logic [15:0] e);
		@(posedge clk_in);
		global_xbus_enable_in <= g;
		xbus_peripheral_enable_reg_in <= e;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		cmp_cfg({periph_active_out, seg_lines_out},
			{g ? e[10:0] : 11'h0, g && |e[1:0] ? 4'h4 : 4'h8});
	endtask

	task automatic conclude();
		n_errors += notes.size();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Result watcher: oldest note against the finished access
	always @(negedge clk_in)
		if (req_ready_out === 1'b1)
		begin
			exp_n = notes.pop_front();
			cmp_route({target_out, req_error_out}, exp_n[5:0]);
			cmp_path({route_addr_out, route_write_out, route_byte_out}, exp_n[36:11]);
			if (exp_n[0] === 1'b0)
				cmp_side({path_wide_out, wait_states_out, standby_area_out, flash_bank_b_out}, exp_n[10:6]);
		end

	// Watchdog
	initial
	begin
		#100us;
		n_errors++;
		conclude();
	end

	// Main sequence
	initial
	begin
		{req_valid_in, req_write_in, req_byte_in, req_fetch_in, bootstrap_pin_in} = '0;
		{global_xbus_enable_in, flash_bank_a_busy_in, flash_bank_b_busy_in, rst_b_in} = '0;
		req_addr_in = '0;
		xbus_peripheral_enable_reg_in = '0;
		dly = '0;
		void'($urandom(32'hb50afca2));
		repeat (4) @(posedge clk_in);
		rst_b_in <= 1'b1;
		cfg(1'b1, 16'h07df);
		for (int i = 0; i < 15; i++)
			acc(map_a[i], 1'b0, 1'b0, i == 0, map_t[i], 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			acc({8'h00, per_p[i], 8'($urandom) & 8'hfe}, 1'($urandom), 1'b0, 1'b0, per_t[i], 1'b0);
			acc({8'h00, per_p[i], 8'h01}, 1'b0, 1'b1, 1'b0, TGT_EXT, 1'b1);
			cfg(1'b1, 16'h07df & ~(16'h0001 << per_b[i]));
			acc({8'h00, per_p[i], 8'h00}, 1'b0, 1'b0, 1'b0, TGT_EXT, 1'b0);
			cfg(1'b1, 16'h07df);
		end
		cfg(1'b1, 16'h07d0);
		acc(24'h00e000, 1'b1, 1'b0, 1'b0, TGT_EXT, 1'b0);
		acc(24'h0f0000, 1'b0, 1'b0, 1'b0, TGT_EXT, 1'b0);
		cfg(1'b0, 16'h07df);
		acc(24'h00e7ff, 1'b0, 1'b1, 1'b0, TGT_EXT, 1'b0);
		acc(24'h0f7fff, 1'b0, 1'b0, 1'b0, TGT_EXT, 1'b0);
		acc(24'h00ef01, 1'b0, 1'b1, 1'b0, TGT_EXT, 1'b0);
		cfg(1'b1, 16'h07df);
		repeat (6)
			acc(24'h00e000 | (24'($urandom) & 24'h0007ff), 1'($urandom), 1'($urandom), 1'b0, TGT_XRS, 1'b0);
		@(posedge clk_in);
		flash_bank_b_busy_in <= 1'b1;
		acc(24'h070000, 1'b0, 1'b0, 1'b0, TGT_EXT, 1'b1);
		acc(24'h06ffff, 1'b0, 1'b0, 1'b1, TGT_FLASH, 1'b0);
		@(posedge clk_in);
		flash_bank_b_busy_in <= 1'b0;
		flash_bank_a_busy_in <= 1'b1;
		acc(24'h018000, 1'b0, 1'b0, 1'b1, TGT_EXT, 1'b1);
		acc(24'h08ffff, 1'b0, 1'b0, 1'b0, TGT_FLASH, 1'b0);
		@(posedge clk_in);
		flash_bank_a_busy_in <= 1'b0;
		bootstrap_pin_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		acc(24'h000000, 1'b0, 1'b0, 1'b1, TGT_TFLASH, 1'b0);
		acc(24'h001fff, 1'b0, 1'b1, 1'b0, TGT_TFLASH, 1'b0);
		acc(24'h002000, 1'b0, 1'b0, 1'b0, TGT_FLASH, 1'b0);
		do @(negedge clk_in); while (busy_out !== 1'b0);
		conclude();
	end
endmodule
